// >>> hw/dcpmc_ctrl.sv
// clock source, divider and operating mode controller
`timescale 1ns/100ps
// Function
// - fast and slow internal RC oscillators provided
// - after reset run slow mode at 80KHz
// - select bit frozen while fast oscillator stopped
// - fast oscillator stop changes only in slow
// - reject abnormal clock control writes
// - divider codes 16,4,2,1; reset divides by 1
// - new divider effective within 16 cycles
// - idle entry halts cpu, peripherals keep running
// - periph stop gates peripheral clocks in idle
// - idle ends on reset or enabled interrupt
// - power-down enters stop, only watchdog runs
// - stop ends on reset or pin wake
// - refuse stop while enabled wake pin low
// - 7-bit trim field, readable and writable
// - factory trim held in config byte
// - 25 ms warm-up then load configuration
module dcpmc_ctrl #(
  parameter int WARMUP_COUNT = dcpmc_pkg::WARMUP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [2:0] extIrqPin,
  input wire logic [2:0] extPinWakeEnable,
  input wire logic irqWake,
  input wire logic pinWake,
  input wire logic wdtEnable,
  input wire logic [6:0] configTrim,
  output logic chipInReset,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic [6:0] fastOscTrim,
  output logic sysClkFast,
  output logic sysClkTick,
  output logic cpuClkEnable,
  output logic periphClkEnable,
  output logic timer3ClkEnable,
  output logic wdtClkEnable
);
  localparam int WCW = $clog2(WARMUP_COUNT + 1);
  localparam logic [WCW-1:0] WARM_LAST = WCW'(WARMUP_COUNT - 1);

  dcpmc_pkg::dcpmc_state_t state_reg;
  dcpmc_pkg::dcpmc_state_t state_next;
  logic [WCW-1:0] warm_reg;
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic periphStop_reg;
  logic fastStop_reg;
  logic fastSel_reg;
  logic [1:0] divField_reg;
  logic [1:0] divActive_reg;
  logic [3:0] divCount_reg;
  logic [6:0] trim_reg;
  logic baudDouble_reg;
  logic flagOne_reg;
  logic flagZero_reg;
  logic [7:0] rdData_reg;
  logic chipInReset_reg;
  logic fastOsc_reg;
  logic slowOsc_reg;
  logic sysFast_reg;
  logic tick_reg;
  logic cpuEn_reg;
  logic periphEn_reg;
  logic timer3En_reg;
  logic wdtEn_reg;

  // address decode
  wire logic hitPower = regAddr == dcpmc_pkg::POWER_CONTROL_OFS;
  wire logic hitClock = regAddr == dcpmc_pkg::CLOCK_CONTROL_OFS;
  wire logic hitTrim = regAddr == dcpmc_pkg::FAST_OSC_TRIM_OFS;
  wire logic running = state_reg == dcpmc_pkg::DCPMC_RUN;
  wire logic wrPower = regWr && hitPower && running;
  wire logic wrClock = regWr && hitClock && running;
  wire logic wrTrim = regWr && hitTrim && running;

  // requested clock control bits
  wire logic reqStop = regWrData[dcpmc_pkg::FAST_OSC_STOP_POS];
  wire logic reqSel = regWrData[dcpmc_pkg::FAST_CLOCK_SELECT_POS];
  wire logic reqPeriph = regWrData[dcpmc_pkg::PERIPH_CLOCK_STOP_POS];
  wire logic [1:0] reqDiv =
    regWrData[dcpmc_pkg::DIVIDER_MSB:dcpmc_pkg::DIVIDER_LSB];

  // stop bit moves only while the slow clock drives the system
  wire logic stopNext = (wrClock && !fastSel_reg) ? reqStop
                                                  : fastStop_reg;
  // select moves only with the fast oscillator running; a write that
  // would leave both bits set has its select refused so the cpu never loses its clock
  wire logic selOk = !fastStop_reg && !(reqSel && stopNext);
  wire logic selNext = (wrClock && selOk) ? reqSel : fastSel_reg;

  // stop is refused while an enabled wake pin is already low
  wire logic pinBlock =
    |(~pinSync_reg & extPinWakeEnable);
  wire logic enterStop = wrPower &&
    regWrData[dcpmc_pkg::POWER_DOWN_POS] && !pinBlock;
  wire logic enterIdle = wrPower &&
    regWrData[dcpmc_pkg::DOZE_ENTRY_POS];

  // divider terminal count from the active code
  wire logic [3:0] divLast =
    (divActive_reg == dcpmc_pkg::DIV_BY_16) ? dcpmc_pkg::LAST_16 :
    (divActive_reg == dcpmc_pkg::DIV_BY_4) ? dcpmc_pkg::LAST_4 :
    (divActive_reg == dcpmc_pkg::DIV_BY_2) ? dcpmc_pkg::LAST_2 :
    dcpmc_pkg::LAST_1;
  wire logic divWrap = divCount_reg >= divLast;
  wire logic clocksHalted = state_reg == dcpmc_pkg::DCPMC_STOP;

  // read mux; entry bits read back the live mode
  wire logic [7:0] powerView = {
    baudDouble_reg, 3'h0, flagOne_reg, flagZero_reg,
    state_reg == dcpmc_pkg::DCPMC_STOP,
    state_reg == dcpmc_pkg::DCPMC_IDLE};
  wire logic [7:0] clockView = {
    3'h0, periphStop_reg, fastStop_reg, fastSel_reg, divField_reg};
  wire logic [7:0] trimView = {1'b0, trim_reg};
  wire logic [7:0] rdMux =
    hitPower ? powerView :
    hitClock ? clockView :
    hitTrim ? trimView :
    8'h00;

  // mode sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dcpmc_pkg::DCPMC_WARM:
      begin
        if (warm_reg == WARM_LAST)
        begin
          state_next = dcpmc_pkg::DCPMC_RUN;
        end
      end
      dcpmc_pkg::DCPMC_RUN:
      begin
        if (enterStop)
        begin
          state_next = dcpmc_pkg::DCPMC_STOP;
        end
        else if (enterIdle)
        begin
          state_next = dcpmc_pkg::DCPMC_IDLE;
        end
      end
      dcpmc_pkg::DCPMC_IDLE:
      begin
        if (irqWake)
        begin
          state_next = dcpmc_pkg::DCPMC_RUN;
        end
      end
      dcpmc_pkg::DCPMC_STOP:
      begin
        if (pinWake)
        begin
          state_next = dcpmc_pkg::DCPMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= dcpmc_pkg::DCPMC_WARM;
      warm_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == dcpmc_pkg::DCPMC_WARM)
      begin
        warm_reg <= warm_reg + WCW'(1);
      end
    end
  end

  // external pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_reg <= 3'h7;
      pinSync_reg <= 3'h7;
    end
    else
    begin
      pinMeta_reg <= extIrqPin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // clock control register; select resets to slow
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periphStop_reg <= 1'b0;
      fastStop_reg <= 1'b0;
      fastSel_reg <= 1'b0;
      divField_reg <= dcpmc_pkg::DIVIDER_RESET;
    end
    else
    begin
      fastStop_reg <= stopNext;
      fastSel_reg <= selNext;
      if (wrClock)
      begin
        periphStop_reg <= reqPeriph;
        divField_reg <= reqDiv;
      end
    end
  end

  // power control flags without hardware meaning
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baudDouble_reg <= 1'b0;
      flagOne_reg <= 1'b0;
      flagZero_reg <= 1'b0;
    end
    else if (wrPower)
    begin
      baudDouble_reg <= regWrData[dcpmc_pkg::BAUD_DOUBLE_POS];
      flagOne_reg <= regWrData[dcpmc_pkg::GENERAL_FLAG_ONE_POS];
      flagZero_reg <= regWrData[dcpmc_pkg::GENERAL_FLAG_ZERO_POS];
    end
  end

  // trim: factory value loaded at the end of warm-up, then software owned
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_reg <= dcpmc_pkg::TRIM_RESET;
    end
    else if (state_reg == dcpmc_pkg::DCPMC_WARM && warm_reg == WARM_LAST)
    begin
      trim_reg <= configTrim;
    end
    else if (wrTrim)
    begin
      trim_reg <= regWrData[dcpmc_pkg::TRIM_MSB:0];
    end
  end

  // divider: a new code is adopted only at a wrap, so the longest wait
  // is one full divide-by-16 period; glitch-free at the cost of latency
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divActive_reg <= dcpmc_pkg::DIVIDER_RESET;
      divCount_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else if (clocksHalted)
    begin
      divCount_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else if (divWrap)
    begin
      divActive_reg <= divField_reg;
      divCount_reg <= 4'h0;
      tick_reg <= 1'b1;
    end
    else
    begin
      divCount_reg <= divCount_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end

  // clock tree enables
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chipInReset_reg <= 1'b1;
      fastOsc_reg <= 1'b0;
      slowOsc_reg <= 1'b1;
      sysFast_reg <= 1'b0;
      cpuEn_reg <= 1'b0;
      periphEn_reg <= 1'b0;
      timer3En_reg <= 1'b0;
      wdtEn_reg <= 1'b0;
    end
    else
    begin
      chipInReset_reg <= state_next == dcpmc_pkg::DCPMC_WARM;
      fastOsc_reg <= !fastStop_reg &&
        state_next != dcpmc_pkg::DCPMC_STOP;
      slowOsc_reg <= state_next != dcpmc_pkg::DCPMC_STOP ||
        wdtEnable;
      sysFast_reg <= fastSel_reg;
      cpuEn_reg <= state_next == dcpmc_pkg::DCPMC_RUN;
      periphEn_reg <= state_next == dcpmc_pkg::DCPMC_RUN ||
        (state_next == dcpmc_pkg::DCPMC_IDLE && !periphStop_reg);
      timer3En_reg <= state_next == dcpmc_pkg::DCPMC_RUN ||
        state_next == dcpmc_pkg::DCPMC_IDLE;
      wdtEn_reg <= wdtEnable &&
        state_next != dcpmc_pkg::DCPMC_WARM;
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_reg <= 8'h00;
    end
    else
    begin
      rdData_reg <= regRd ? rdMux : 8'h00;
    end
  end

  assign regRdData = rdData_reg;
  assign chipInReset = chipInReset_reg;
  assign fastOscEnable = fastOsc_reg;
  assign slowOscEnable = slowOsc_reg;
  assign fastOscTrim = trim_reg;
  assign sysClkFast = sysFast_reg;
  assign sysClkTick = tick_reg;
  assign cpuClkEnable = cpuEn_reg;
  assign periphClkEnable = periphEn_reg;
  assign timer3ClkEnable = timer3En_reg;
  assign wdtClkEnable = wdtEn_reg;
endmodule

// >>> hw/dcpmc_pkg.sv
// shared constants for the dual clock and power mode controller
package dcpmc_pkg;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'h87;
  localparam logic [7:0] CLOCK_CONTROL_OFS = 8'hD8;
  localparam logic [7:0] FAST_OSC_TRIM_OFS = 8'hF6;
  // power control fields
  localparam int DOZE_ENTRY_POS = 0;
  localparam int POWER_DOWN_POS = 1;
  localparam int GENERAL_FLAG_ZERO_POS = 2;
  localparam int GENERAL_FLAG_ONE_POS = 3;
  localparam int BAUD_DOUBLE_POS = 7;
  // clock control and trim fields
  localparam int DIVIDER_LSB = 0;
  localparam int DIVIDER_MSB = 1;
  localparam int FAST_CLOCK_SELECT_POS = 2;
  localparam int FAST_OSC_STOP_POS = 3;
  localparam int PERIPH_CLOCK_STOP_POS = 4;
  localparam int TRIM_MSB = 6;
  localparam logic [1:0] DIVIDER_RESET = 2'h3;
  localparam logic [6:0] TRIM_RESET = 7'h00;
  // divider codes and terminal counts (divisor minus one)
  localparam logic [1:0] DIV_BY_16 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_2 = 2'h2;
  localparam logic [1:0] DIV_BY_1 = 2'h3;
  localparam logic [3:0] LAST_16 = 4'hF;
  localparam logic [3:0] LAST_4 = 4'h3;
  localparam logic [3:0] LAST_2 = 4'h1;
  localparam logic [3:0] LAST_1 = 4'h0;
  // nominal oscillator rates, informational for the clock tree
  localparam int FAST_OSC_KHZ_HIGH = 16589;
  localparam int FAST_OSC_KHZ_LOW = 8294;
  localparam int SLOW_OSC_KHZ = 80;
  // warm-up after power-on
  localparam int REF_CLK_MHZ = 100;
  localparam int WARMUP_MS = 25;
  localparam int WARMUP_CYCLES = WARMUP_MS * 1000 * REF_CLK_MHZ;
  localparam int EXT_PINS = 3;
  typedef enum logic [1:0] {
    DCPMC_WARM = 2'b00,
    DCPMC_RUN = 2'b01,
    DCPMC_IDLE = 2'b10,
    DCPMC_STOP = 2'b11
  } dcpmc_state_t;
endpackage

// >>> tb/dcpmc_ctrl_sva.sv
// port checker for the clock and mode controller
`timescale 1ns/100ps
module dcpmc_ctrl_chk #(
  parameter int WARMUP_COUNT = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] extIrqPin,
  input wire logic [2:0] extPinWakeEnable,
  input wire logic irqWake,
  input wire logic pinWake,
  input wire logic wdtEnable,
  input wire logic [6:0] configTrim,
  input wire logic chipInReset,
  input wire logic fastOscEnable,
  input wire logic [6:0] fastOscTrim,
  input wire logic sysClkFast,
  input wire logic sysClkTick,
  input wire logic cpuClkEnable,
  input wire logic periphClkEnable,
  input wire logic timer3ClkEnable,
  input wire logic wdtClkEnable
);
  logic [4:0] gap_reg;
  wire logic inStop = !chipInReset && !timer3ClkEnable;
  wire logic inIdle = timer3ClkEnable && !cpuClkEnable;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since the last tick; saturates so a stuck divider still trips
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_reg <= 5'h00;
    else if (sysClkTick || !timer3ClkEnable)
      gap_reg <= 5'h00;
    else if (gap_reg != 5'h1F)
      gap_reg <= gap_reg + 5'h01;
  end
  a_reset_slow_mode: assert property (
    $fell(chipInReset) |-> !sysClkFast)
    else $error("clock not slow after warm-up");
  a_warmup_trim: assert property (
    $fell(chipInReset) |-> fastOscTrim == configTrim)
    else $error("trim not loaded at warm-up end");
  a_fast_osc_on: assert property (
    cpuClkEnable && sysClkFast |-> fastOscEnable)
    else $error("fast clock selected while stopped");
  a_stop_clocks_off: assert property (
    inStop |-> !cpuClkEnable && !periphClkEnable && !fastOscEnable &&
    wdtClkEnable == wdtEnable)
    else $error("clock running in stop");
  a_idle_entry: assert property (
    regWr && regAddr == 8'h87 && regWrData[1:0] == 2'h1 && cpuClkEnable
    |=> inIdle)
    else $error("idle not entered");
  a_idle_wake: assert property (inIdle && irqWake |=> cpuClkEnable)
    else $error("idle not left on interrupt");
  a_stop_wake: assert property (inStop && pinWake |=> cpuClkEnable)
    else $error("stop not left on pin wake");
  a_stop_held: assert property (inStop && !pinWake |=> inStop)
    else $error("stop left without pin wake");
  a_stop_refused: assert property (
    regWr && regAddr == 8'h87 && cpuClkEnable &&
    (~extIrqPin & ~$past(extIrqPin) & ~$past(extIrqPin, 2) &
    extPinWakeEnable) != 3'h0 |=> !inStop)
    else $error("stop entered with pin low");
  a_tick_gap: assert property (timer3ClkEnable |-> gap_reg < 5'h11)
    else $error("divided tick too late");
  a_trim_readback: assert property (
    regRd && regAddr == 8'hF6 |=> regRdData == {1'b0, $past(fastOscTrim)})
    else $error("trim read mismatch");
  c_idle: cover property (inIdle);
  c_stop: cover property (inStop);
  c_fast: cover property ($rose(sysClkFast));
endmodule
bind dcpmc_ctrl dcpmc_ctrl_chk #(.WARMUP_COUNT(WARMUP_COUNT)) u_chk (.*);

// >>> tb/test_dual_clock_power_mode_ctrl.sv
// self-checking bench for the clock and mode controller
`timescale 1ns/100ps
module test_dual_clock_power_mode_ctrl;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [2:0] extIrqPin = 3'h7;
  logic [2:0] extPinWakeEnable = 3'h0;
  logic irqWake = 1'b0;
  logic pinWake = 1'b0;
  logic wdtEnable = 1'b0;
  logic [6:0] configTrim = 7'h00;
  logic [7:0] regRdData;
  logic [6:0] fastOscTrim;
  logic chipInReset, fastOscEnable, slowOscEnable, sysClkFast, sysClkTick;
  logic cpuClkEnable, periphClkEnable, timer3ClkEnable, wdtClkEnable;
  logic [7:0] lfsr = 8'h60;
  logic [7:0] clkModel = 8'h03;
  int divs[4] = '{16, 4, 2, 1};
  // select, stop in fast mode, stop in slow, select while stopped
  logic [7:0] selSeq[4] = '{8'h07, 8'h0B, 8'h0B, 8'h07};
  int error_cnt = 0;
  int cmp_count = 0;
  int p;
  dcpmc_ctrl #(.WARMUP_COUNT(20)) uut (.*);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask
  // distance between the second and third tick seen
  task automatic period(output int q);
    int n;
    int t0;
    n = 0;
    t0 = 0;
    q = 0;
    for (int i = 1; i < 80 && n < 3; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (sysClkTick === 1'b1)
      begin
        q = i - t0;
        t0 = i;
        n++;
      end
    end
  endtask
  // bit 2 refused while stopped or paired with stop; stop needs slow select
  function automatic logic [7:0] clk_next(input logic [7:0] c, input logic [7:0] d);
    logic stopN;
    logic selN;
    stopN = c[2] ? c[3] : d[3];
    selN = (!c[3] && !(d[2] && stopN)) ? d[2] : c[2];
    return (d & 8'h13) | {4'h0, stopN, selN, 2'h0};
  endfunction
  // one-cycle wake event: pin wake when pin is set, else interrupt wake
  task automatic pulse(input logic pin);
    @(posedge ref_clk);
    if (pin)
      pinWake <= 1'b1;
    else
      irqWake <= 1'b1;
    @(posedge ref_clk);
    pinWake <= 1'b0;
    irqWake <= 1'b0;
    #1;
  endtask
  // bounded wait for the end of warm-up
  task automatic await_run;
    for (int n = 0; n < 40 && chipInReset !== 1'b0; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    check({7'h0, chipInReset}, 8'h00);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial
  begin
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    configTrim <= lfsr[6:0];
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'hF6, 8'h55);
    check({7'h0, chipInReset}, 8'h01);
    rdchk(8'hD8, 8'h03);
    await_run();
    rdchk(8'hF6, {1'b0, configTrim});
    check({7'h0, sysClkFast}, 8'h00);
    rdchk(8'h87, 8'h00);
    rdchk(8'h10, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      wr(8'hF6, lfsr);
      rdchk(8'hF6, {1'b0, lfsr[6:0]});
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(8'hD8, 8'(c));
      period(p);
      check(8'(p), 8'(divs[c]));
    end
    foreach (selSeq[k])
    begin
      repeat (16) @(posedge ref_clk);
      clkModel = clk_next(clkModel, selSeq[k]);
      wr(8'hD8, selSeq[k]);
      // source and oscillator enables follow the register a cycle later
      @(posedge ref_clk);
      #1;
      check({7'h0, sysClkFast}, {7'h0, clkModel[2]});
      check({7'h0, fastOscEnable}, {7'h0, !clkModel[3]});
      rdchk(8'hD8, clkModel);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(8'hD8, k ? 8'h13 : 8'h03);
      wr(8'h87, 8'h01);
      check({cpuClkEnable, timer3ClkEnable}, 8'h01);
      check({7'h0, periphClkEnable}, 8'(k == 0));
      rdchk(8'h87, 8'h01);
      pulse(1'b0);
      check({7'h0, cpuClkEnable}, 8'h01);
      rdchk(8'h87, 8'h00);
    end
    wr(8'h87, 8'h8C);
    rdchk(8'h87, 8'h8C);
    @(posedge ref_clk);
    extIrqPin <= 3'h6;
    extPinWakeEnable <= 3'h1;
    repeat (3) @(posedge ref_clk);
    wr(8'h87, 8'h02);
    check({7'h0, cpuClkEnable}, 8'h01);
    @(posedge ref_clk);
    extIrqPin <= 3'h7;
    wdtEnable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(8'h87, 8'h02);
    check({cpuClkEnable, fastOscEnable, slowOscEnable, wdtClkEnable},
      8'h03);
    pulse(1'b0);
    check({7'h0, cpuClkEnable}, 8'h00);
    pulse(1'b1);
    check({7'h0, cpuClkEnable}, 8'h01);
    rdchk(8'h87, 8'h00);
    // a reset taken in fast mode must come back slow
    repeat (16) @(posedge ref_clk);
    wr(8'hD8, 8'h17);
    @(posedge ref_clk);
    #1;
    check({7'h0, sysClkFast}, 8'h01);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    await_run();
    check({7'h0, sysClkFast}, 8'h00);
    rdchk(8'hD8, 8'h03);
    final_report();
  end
endmodule
